// file: src/sdim_top.sv
`timescale 1ns/1ps
`include "sdim_defs.svh"
// What the document requires
// R1 - accesses are bursts of four or eight beats from start column in order
// R2 - activate: bank select bits pick bank, A0-A12 pick row
// R3 - read/write: address gives start column and auto precharge flag
// R4 - controller holds clock enable and termination control low at power-up
// R5 - controller waits 200 us with stable clock, then raises clock enable
// R6 - controller waits 400 ns of idle commands, then precharges all
// R7 - controller writes extended registers 2 then 3
// R8 - controller writes extended register 1 enabling the DLL
// R9 - controller writes mode register with A8 high, resetting DLL
// R10 - controller precharges all then issues two or more refreshes
// R11 - controller rewrites mode register with A8 low
// R12 - calibration only 200 clocks after DLL reset write, then ready
// R13 - without calibration write calibration field all ones then zeros
// R14 - mode register undefined after power-up; must be written first
// R15 - mode write: select, strobes, write enable, bank bits all low
// R16 - mode writes only with banks precharged, clock enable high
// R17 - mode fields: length, order, latency, test, DLL reset, recovery
// R18 - controller keeps test mode bit low
// R19 - read latency only in whole clocks
// R20 - controller rewrites every field on any change
// R21 - mode writes and DLL reset leave array contents intact
// R22 - controller programs write recovery to speed grade minimum
// R23 - 200 clocks after DLL enable and reset before any read
// R24 - fields latched on the command edge, applied after write cycle time
module sdim_top
    import sdim_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        LINK_CK,
    input  wire logic        CKE,
    input  wire logic        TERMINATION_CONTROL,
    input  wire logic        CS_N,
    input  wire logic        RAS_N,
    input  wire logic        CAS_N,
    input  wire logic        WE_N,
    input  wire logic [1:0]  BANK_SELECT,
    input  wire logic [12:0] ADDR,
    output logic [15:0]      MODE_SETTING,
    output logic [15:0]      EXT1_SETTING,
    output logic             MODE_VALID,
    output logic             DLL_READY,
    output logic [3:0]       OPEN_BANKS,
    output logic             BURST_ACTIVE,
    output logic             BURST_WRITE,
    output logic [1:0]       BURST_BANK,
    output logic [12:0]      BURST_ROW,
    output logic [9:0]       BURST_COL,
    output logic             AUTO_PRECHARGE,
    output logic             TERM_ACTIVE
);

    sdim_pins_type  pins_s1;
    sdim_pins_type  pins_s2;
    logic [2:0]     ck_sync;
    logic [1:0]     term_sync;
    sdim_state_type state;
    logic [12:0]    row_mem [4];
    logic           pend_valid;
    logic [15:0]    pend_data;
    logic           pend_ext;
    logic [3:0]     mwc_cnt;
    logic [7:0]     dll_cnt;
    logic [2:0]     beat;
    logic [9:0]     start_col;

    // two-stage sampling of all pins, link clock has a third stage
    wire sdim_pins_type pins_in = '{cke: CKE, cs_n: CS_N, ras_n: RAS_N,
        cas_n: CAS_N, we_n: WE_N, ba: BANK_SELECT, a: ADDR};
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pins_s1   <= '0;
            pins_s2   <= '0;
            ck_sync   <= 3'h0;
            term_sync <= 2'h0;
        end else begin
            pins_s1   <= pins_in;
            pins_s2   <= pins_s1;
            ck_sync   <= {ck_sync[1:0], LINK_CK};
            term_sync <= {term_sync[0], TERMINATION_CONTROL};
        end
    end

    wire ck_rise = ck_sync[1] & ~ck_sync[2];
    wire ck_edge = ck_sync[1] ^ ck_sync[2];

    // command decode on the rising link clock edge
    wire       sel     = ck_rise & pins_s2.cke & ~pins_s2.cs_n;
    wire [2:0] rcw     = {pins_s2.ras_n, pins_s2.cas_n, pins_s2.we_n};
    wire       all_idl = (OPEN_BANKS == 4'h0);
    wire       cmd_mrw = sel & (rcw == 3'b000);                 // R15
    wire       cmd_act = sel & (rcw == 3'b011);                 // R2
    wire       cmd_rd  = sel & (rcw == 3'b101);                 // R3
    wire       cmd_wr  = sel & (rcw == 3'b100);                 // R3
    wire       cmd_pre = sel & (rcw == 3'b010);
    wire [1:0] ba      = pins_s2.ba;
    wire       sel_md  = (ba == `SDIM_SEL_MODE);
    wire       sel_e1  = (ba == `SDIM_SEL_EXT1);
    wire       mrw_ok  = cmd_mrw & all_idl & (sel_md | sel_e1);
    wire       dll_rst = mrw_ok & sel_md & pins_s2.a[`SDIM_MODE_DLL_RST];
    wire       dll_dis = mrw_ok & sel_e1 & pins_s2.a[`SDIM_EXT1_DLL_DIS];
    wire       md_due  = pend_valid & ck_rise & (mwc_cnt == 4'h1);

    // burst shape from the applied setting
    wire [2:0] bl_code = MODE_SETTING[`SDIM_MODE_BL_MSB:`SDIM_MODE_BL_LSB];
    wire       bl8     = (bl_code == `SDIM_BL8_CODE);
    wire [2:0] bl_last = bl8 ? 3'h7 : 3'h3;
    wire       order_i = MODE_SETTING[`SDIM_MODE_ORDER];
    wire       acc_ok  = MODE_VALID & OPEN_BANKS[ba] & (state == SDIM_IDLE);
    wire       b_start = (cmd_rd | cmd_wr) & acc_ok;
    wire       b_end   = (state == SDIM_BURST) & ck_edge & (beat == bl_last);
    wire [2:0] seq_low = start_col[2:0] + beat;
    wire [2:0] int_low = start_col[2:0] ^ beat;
    wire [2:0] low     = order_i ? int_low : seq_low;
    wire [9:0] col_now = bl8 ? {start_col[9:3], low}
                             : {start_col[9:2], low[1:0]};         // R1

    // latch on the command edge, apply after write cycle time
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pend_valid <= 1'b0;
            pend_data  <= 16'h0000;
            pend_ext   <= 1'b0;
            mwc_cnt    <= 4'h0;
        end else if (mrw_ok) begin
            pend_valid <= 1'b1;                                  // R24
            pend_data  <= {3'h0, pins_s2.a};
            pend_ext   <= sel_e1;
            mwc_cnt    <= `SDIM_MWC_CLK;
        end else if (pend_valid && ck_rise) begin
            mwc_cnt    <= mwc_cnt - 4'h1;
            pend_valid <= (mwc_cnt != 4'h1);
        end
    end

    // no array state here is touched by register writes
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            MODE_SETTING <= `SDIM_MODE_RESET;
            EXT1_SETTING <= `SDIM_EXT1_RESET;
            MODE_VALID   <= 1'b0;                                // R14
        end else if (md_due && pend_ext) begin
            EXT1_SETTING <= pend_data;                           // R21
        end else if (md_due) begin
            MODE_SETTING <= pend_data;                           // R17
            MODE_VALID   <= 1'b1;                                // R14
        end
    end

    // whole-clock latency only: field passed on as written
    wire [2:0] rd_lat =
        MODE_SETTING[`SDIM_MODE_RL_MSB:`SDIM_MODE_RL_LSB];       // R19

    // DLL settle count in link clocks
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            dll_cnt   <= 8'h00;
            DLL_READY <= 1'b0;
        end else if (dll_rst || dll_dis) begin
            dll_cnt   <= 8'h00;
            DLL_READY <= 1'b0;
        end else if (ck_rise && !DLL_READY) begin
            dll_cnt   <= dll_cnt + 8'h01;
            DLL_READY <= (dll_cnt == `SDIM_DLL_LOCK_CLK - 8'h01);
        end
    end

    // bank open state and row memory
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bank
            wire hit = (ba == 2'(g));
            wire opn = cmd_act & hit & ~OPEN_BANKS[g];
            wire cls = (cmd_pre & (hit | pins_s2.a[`SDIM_AUTO_PRE]))
                     | (b_end & AUTO_PRECHARGE & (BURST_BANK == 2'(g)));
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    OPEN_BANKS[g] <= 1'b0;
                    row_mem[g]    <= 13'h0000;
                end else if (opn) begin
                    OPEN_BANKS[g] <= 1'b1;                       // R2
                    row_mem[g]    <= pins_s2.a;                  // R2
                end else if (cls) begin
                    OPEN_BANKS[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // burst sequencer, one beat per link clock edge
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state          <= SDIM_IDLE;
            beat           <= 3'h0;
            start_col      <= 10'h000;
            BURST_WRITE    <= 1'b0;
            BURST_BANK     <= 2'h0;
            BURST_ROW      <= 13'h0000;
            AUTO_PRECHARGE <= 1'b0;
        end else begin
            unique case (state)
                SDIM_IDLE: begin
                    if (b_start) begin
                        state          <= SDIM_BURST;
                        beat           <= 3'h0;
                        start_col      <= pins_s2.a[9:0];        // R3
                        BURST_WRITE    <= cmd_wr;
                        BURST_BANK     <= ba;
                        BURST_ROW      <= row_mem[ba];
                        AUTO_PRECHARGE <= pins_s2.a[`SDIM_AUTO_PRE]; // R3
                    end
                end
                SDIM_BURST: begin
                    if (b_end) begin
                        state <= SDIM_IDLE;                      // R1
                    end else if (ck_edge) begin
                        beat  <= beat + 3'h1;                    // R1
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            BURST_ACTIVE <= 1'b0;
            BURST_COL    <= 10'h000;
            TERM_ACTIVE  <= 1'b0;
        end else begin
            BURST_ACTIVE <= (state == SDIM_BURST) & ~b_end;
            BURST_COL    <= col_now;
            TERM_ACTIVE  <= term_sync[1] & pins_s2.cke;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    a_mode_apply_time: assert property ( // R24
        mrw_ok && sel_md |-> ##[1:40] md_due)
        else $error("mode write not applied");
    a_mode_from_pend: assert property ( // R17
        md_due && !pend_ext |=> MODE_SETTING == $past(pend_data))
        else $error("bad mode");
    a_mode_valid_hold: assert property ( // R14
        !$past(MODE_VALID) && MODE_VALID |-> $past(md_due))
        else $error("valid without write");
    a_burst_needs_mode: assert property ( // R14
        BURST_ACTIVE |-> MODE_VALID)
        else $error("burst before mode");
    a_burst_row: assert property ( // R2
        b_start |=> ##1 BURST_ROW == row_mem[BURST_BANK])
        else $error("row lost");
    a_burst_first_col: assert property ( // R1
        b_start |=> ##1 BURST_COL == start_col)
        else $error("bad first column");
    a_burst_length: assert property ( // R1
        state == SDIM_BURST && !b_end |=> state == SDIM_BURST)
        else $error("burst cut");
    a_burst_bound: assert property ( // R1
        b_start |-> ##[1:300] b_end)
        else $error("burst too long");
    a_auto_close: assert property ( // R3
        b_end && AUTO_PRECHARGE |=> !OPEN_BANKS[$past(BURST_BANK)])
        else $error("no auto close");
    a_array_kept: assert property ( // R21
        mrw_ok |=> $stable(OPEN_BANKS))
        else $error("mode write changed banks");
    a_latency_kept: assert property ( // R19
        md_due && !pend_ext |=> rd_lat == $past(pend_data[6:4]))
        else $error("bad latency");

    c_mode_write: cover property (md_due && !pend_ext);
    c_dll_ready: cover property ($rose(DLL_READY));
    c_burst8: cover property (b_end && bl8);
    c_auto_pre: cover property (b_end && AUTO_PRECHARGE);

endmodule : sdim_top

// file: src/sdim_defs.svh
`ifndef SDIM_DEFS_SVH
`define SDIM_DEFS_SVH

// address field positions of the mode and extended 1 settings and of the auto precharge flag
`define SDIM_MODE_BL_LSB  0
`define SDIM_MODE_BL_MSB  2
`define SDIM_MODE_ORDER   3
`define SDIM_MODE_RL_LSB  4
`define SDIM_MODE_RL_MSB  6
`define SDIM_MODE_TEST    7
`define SDIM_MODE_DLL_RST 8
`define SDIM_MODE_WR_LSB  9
`define SDIM_MODE_WR_MSB  11
`define SDIM_EXT1_DLL_DIS 0
`define SDIM_AUTO_PRE     10

// burst length codes
`define SDIM_BL4_CODE     3'h2
`define SDIM_BL8_CODE     3'h3

// bank select codes of the write-type commands
`define SDIM_SEL_MODE     2'h0
`define SDIM_SEL_EXT1     2'h1

// reset values
`define SDIM_MODE_RESET   16'h0000
`define SDIM_EXT1_RESET   16'h0000

// timing counts, in link clock cycles
`define SDIM_MWC_CLK      4'h2
`define SDIM_DLL_LOCK_CLK 8'hC8

`endif

// file: src/sdim_pkg.sv
package sdim_pkg;

    // sampled command and address pins
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] a;
    } sdim_pins_type;

    typedef enum logic [1:0] {
        SDIM_IDLE  = 2'b01,
        SDIM_BURST = 2'b10
    } sdim_state_type;

endpackage : sdim_pkg

// file: dv/sdim_ctrl_model.sv
`timescale 1ns/1ps
module sdim_ctrl_model
    import sdim_pkg::*;
(
    output logic          link_ck,
    output logic          term_ctl,
    output sdim_pins_type pins
);
    // documented as a stable, free running clock
    initial begin
        link_ck = 1'b0;
        #37;
        forever #200 link_ck = ~link_ck;
    end

    initial begin
        term_ctl = 1'b0;
        pins     = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    end

    // pins change on the falling edge, stable around the rise
    task automatic issue(input logic [2:0] rcw, input logic [1:0] ba,
                         input logic [12:0] a, input int gap);
        @(negedge link_ck);
        pins.cs_n = 1'b0;
        {pins.ras_n, pins.cas_n, pins.we_n} = rcw;
        pins.ba = ba;
        pins.a  = a;
        @(negedge link_ck);
        pins.cs_n = 1'b1;
        {pins.ras_n, pins.cas_n, pins.we_n} = ~rcw;
        pins.ba = ~ba;
        pins.a  = ~a;
        repeat (gap) @(negedge link_ck);
    endtask : issue

    task automatic init_seq(input logic [12:0] mode, input logic [12:0] ext);
        repeat (500) @(posedge link_ck);
        pins.cke = 1'b1;
        repeat (2) @(posedge link_ck);
        issue(3'b010, 2'h0, 13'h0400, 1);
        issue(3'b000, 2'h2, 13'h0000, 2);
        issue(3'b000, 2'h3, 13'h0000, 2);
        issue(3'b000, 2'h1, ext & 13'h0C7E, 2);
        issue(3'b000, 2'h0, mode | 13'h0100, 2);
        issue(3'b010, 2'h0, 13'h0400, 1);
        issue(3'b001, 2'h0, 13'h0000, 2);
        issue(3'b001, 2'h0, 13'h0000, 2);
        issue(3'b000, 2'h0, mode & 13'h1E7F, 2);
        repeat (200) @(posedge link_ck);
        issue(3'b000, 2'h1, (ext & 13'h0C7E) | 13'h0380, 2);
        issue(3'b000, 2'h1, ext & 13'h0C7E, 2);
    endtask : init_seq
endmodule : sdim_ctrl_model

// file: dv/sdim_top_tb_top.sv
`timescale 1ns/1ps
module sdim_top_tb_top;
    logic                  mclk;
    logic                  resetn;
    wire                   link_ck;
    wire                   term_ctl;
    sdim_pkg::sdim_pins_type pins;
    logic [15:0]           mode_setting;
    logic [15:0]           ext1_setting;
    logic                  mode_valid;
    logic                  dll_ready;
    logic [3:0]            open_banks;
    logic                  burst_active;
    logic                  burst_write;
    logic [1:0]            burst_bank;
    logic [12:0]           burst_row;
    logic [9:0]            burst_col;
    logic                  auto_precharge;
    logic                  term_active;
    int                    num_errors;
    int                    num_checks;
    int                    cycles;

    sdim_ctrl_model i_model (.link_ck(link_ck), .term_ctl(term_ctl),
        .pins(pins));

    sdim_top i_dut (.MCLK(mclk), .RESETN(resetn), .LINK_CK(link_ck),
        .CKE(pins.cke), .TERMINATION_CONTROL(term_ctl), .CS_N(pins.cs_n),
        .RAS_N(pins.ras_n), .CAS_N(pins.cas_n), .WE_N(pins.we_n),
        .BANK_SELECT(pins.ba), .ADDR(pins.a), .MODE_SETTING(mode_setting),
        .EXT1_SETTING(ext1_setting), .MODE_VALID(mode_valid),
        .DLL_READY(dll_ready), .OPEN_BANKS(open_banks),
        .BURST_ACTIVE(burst_active), .BURST_WRITE(burst_write),
        .BURST_BANK(burst_bank), .BURST_ROW(burst_row),
        .BURST_COL(burst_col), .AUTO_PRECHARGE(auto_precharge),
        .TERM_ACTIVE(term_active));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : check

    // collects the columns of one burst; n of zero means no burst
    task automatic run_burst(input int n, input logic [9:0] start,
        input bit ilv, input logic [1:0] bank, input logic [12:0] row,
        input bit wr);
        logic [9:0] q[$];
        logic [9:0] base;
        logic [9:0] msk;
        int         k;
        msk  = 10'(n - 1);
        base = start & ~msk;
        k    = 0;
        while (burst_active !== 1'b1 && k < 40) begin
            @(negedge mclk);
            k++;
        end
        check({15'h0, burst_active}, {15'h0, n > 0}, "burst start");
        if (n > 0) begin
            check({13'h0, burst_write, burst_bank}, {13'h0, wr, bank}, "bank");
            check({3'h0, burst_row}, {3'h0, row}, "row");
            k = 0;
            while (burst_active === 1'b1 && k < 100) begin
                if (q.size() == 0 || q[$] !== burst_col) q.push_back(burst_col);
                @(negedge mclk);
                k++;
            end
            check(16'(q.size()), 16'(n), "beats");
            for (k = 0; k < q.size() && k < n; k++) begin
                check({6'h0, q[k]}, {6'h0, ilv ? base | ((start ^ 10'(k)) & msk)
                      : base | ((start + 10'(k)) & msk)}, "column");
            end
        end
    endtask : run_burst

    task automatic t_reset();
        check(mode_setting, 16'h0000, "mode at reset");
        check({12'h0, mode_valid, dll_ready, burst_active, term_active},
              16'h0000, "flags at reset");
    endtask : t_reset

    task automatic t_init();
        i_model.init_seq(13'h0653, 13'h0042);
        repeat (3) @(posedge link_ck);
        @(negedge mclk);
        check(mode_setting, 16'h0653, "mode after init");
        check(ext1_setting, 16'h0042, "ext1 after init");
        check({14'h0, mode_valid, dll_ready}, 16'h0003, "ready");
        #3 i_model.term_ctl = 1'b1;
        repeat (5) @(negedge mclk);
        check({15'h0, term_active}, 16'h0001, "termination");
    endtask : t_init

    task automatic t_access();
        i_model.issue(3'b011, 2'h2, 13'h1234, 1);
        @(negedge mclk);
        check({12'h0, open_banks}, 16'h0004, "open banks");
        i_model.issue(3'b000, 2'h0, 13'h0652, 4);
        check(mode_setting, 16'h0653, "refused mode");
        i_model.issue(3'b101, 2'h2, 13'h0406, 0);
        check({15'h0, auto_precharge}, 16'h0001, "auto precharge");
        run_burst(8, 10'h006, 1'b0, 2'h2, 13'h1234, 1'b0);
        repeat (4) @(negedge mclk);
        check({12'h0, open_banks}, 16'h0000, "auto close");
    endtask : t_access

    task automatic t_remode();
        i_model.issue(3'b000, 2'h0, 13'h065A, 0);
        check(mode_setting, 16'h0653, "not yet applied");
        repeat (3) @(posedge link_ck);
        @(negedge mclk);
        check(mode_setting, 16'h065A, "new mode");
        i_model.issue(3'b011, 2'h1, 13'h0ABC, 1);
        i_model.issue(3'b101, 2'h3, 13'h0001, 0);
        run_burst(0, 10'h001, 1'b0, 2'h3, 13'h0000, 1'b0);
        i_model.issue(3'b100, 2'h1, 13'h0005, 0);
        check({15'h0, auto_precharge}, 16'h0000, "no auto precharge");
        run_burst(4, 10'h005, 1'b1, 2'h1, 13'h0ABC, 1'b1);
        check({12'h0, open_banks}, 16'h0002, "bank kept");
    endtask : t_remode

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        cycles     = 0;
        resetn     = 1'b0;
        repeat (20) @(posedge mclk);
        #2 resetn = 1'b1;
        t_reset();
        t_init();
        t_access();
        t_remode();
        results();
    end
endmodule : sdim_top_tb_top
